// File: rtl/tmr_pair.sv
// two 16-bit timer channels: interval, event count, capture, pwm, output combine
// assumes synchronous pins, level prescaler taps, and a ram owner that
// increments its pointer on every ram_ptr_inc_out pulse within one cycle
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps

// Contract
// - clear/start: 0 stops, 1 clears and starts
// - pause bit holds or continues the count
// - count-plus-one bit includes the zero state
// - source field picks event pin or capture
// - second timer clock select and fast taps
// - third timer clock select incl serial clock
// - pwm bit selects timer or pwm mode
// - capture-to-ram bit enables automatic store
// - store low then high byte, pointer increments
// - irq every overflow or every second
// - output polarity normal or inverted
// - count clock used plain or inverted
// - combine outputs by and/or/nand/nor
// - counter read as low then high byte
// - data addresses read counter, write buffers
// - pwm buffers: duty, period, extension, cycle
// - buffers move to active at start/reload
module tmr_pair (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic [8:0] prescale_tap_in,
  input  wire logic       first_timer_output_in,
  input  wire logic       serial_iface_clock_in,
  input  wire logic       serial_clock_select_in,
  input  wire logic       event_pin_a_in,
  input  wire logic       event_pin_b_in,
  input  wire logic       event_pin_c_in,
  input  wire logic       ext_irq_a_in,
  input  wire logic       ext_irq_b_in,
  input  wire logic       ext_irq_c_in,
  input  wire logic [7:0] ram_ptr_in,
  output logic      [7:0] ram_addr_out,
  output logic      [7:0] ram_wdata_out,
  output logic            ram_we_out,
  output logic            ram_ptr_inc_out,
  output logic            second_timer_output_out,
  output logic            third_timer_output_out,
  output logic            combined_output_out,
  output logic      [1:0] tmr_irq_out
);

  typedef struct packed {
    // register file and buffers
    logic [1:0][7:0]      mode_a;
    logic [1:0][7:0]      mode_b;
    logic [1:0][3:0][7:0] dbuf;
    logic [1:0][3:0][7:0] dact;
    // counting and capture state
    logic [1:0][15:0]     cnt;
    logic [1:0][15:0]     cap;
    logic [1:0][7:0]      hi_latch;
    logic [1:0]           clk_prev;
    logic [1:0]           cap_prev;
    logic [1:0]           half;
    logic [1:0]           raw;
    logic [1:0]           outp;
    logic [1:0]           irq;
    logic [1:0]           pend;
    logic                 comb;
    logic                 ps0_half;
    logic                 ps0_prev;
    // capture store engine
    tmr_pair_pkg::store_e st;
    logic                 st_ch;
    logic [15:0]          st_data;
    // registered outputs
    logic                 ram_we;
    logic                 ram_inc;
    logic [7:0]           ram_addr;
    logic [7:0]           ram_wdata;
    logic [7:0]           rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // pin vectors indexed by channel plus source bit
  logic [2:0] event_pins;
  logic [2:0] ext_irqs;

  // pins gathered so each channel can index its own pair
  assign event_pins = {event_pin_c_in, event_pin_b_in, event_pin_a_in};
  assign ext_irqs   = {ext_irq_c_in, ext_irq_b_in, ext_irq_a_in};

  // next-state logic for both channels, bus and store engine
  always_comb begin
    // scratch values shared by both channels
    logic       src_clk;
    logic       edge_in;
    logic       tick;
    logic       cap_sig;
    logic       ovf;
    logic       start;
    logic       fast;
    logic [2:0] ck;
    // byte-wide halves of the count
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] end_lo;
    logic [8:0] duty_x;
    logic [15:0] match;

    // scratch defaults, so nothing is latched
    src_clk = 1'b0;
    edge_in = 1'b0;
    tick = 1'b0;
    cap_sig = 1'b0;
    ovf = 1'b0;
    start = 1'b0;
    fast = 1'b0;
    ck = 3'h0;
    lo = 8'h00;
    hi = 8'h00;
    end_lo = 8'h00;
    duty_x = 9'h000;
    match = 16'h0000;

    // hold all state, then drop the one-cycle pulses
    state_nxt = state_r;
    state_nxt.irq = 2'b00;
    state_nxt.ram_we = 1'b0;
    state_nxt.ram_inc = 1'b0;

    // ps0 divided by two for fast-mode clock code 0
    state_nxt.ps0_prev = prescale_tap_in[0];
    if (prescale_tap_in[0] && !state_r.ps0_prev) begin
      state_nxt.ps0_half = !state_r.ps0_half;
    end

    // capture store engine, runs before channels so a new capture wins
    case (state_r.st)
      tmr_pair_pkg::ST_IDLE: begin
        // second timer first when both wait
        if (state_r.pend[0] || state_r.pend[1]) begin
          state_nxt.st_ch = !state_r.pend[0];
          state_nxt.st_data = state_r.pend[0] ? state_r.cap[0] : state_r.cap[1];
          state_nxt.pend[!state_r.pend[0]] = 1'b0;
          state_nxt.st = tmr_pair_pkg::ST_LOW;
        end
      end

      tmr_pair_pkg::ST_LOW: begin
        // low byte at the pointer; owner steps it one edge after the registered pulse
        state_nxt.ram_we = 1'b1;
        state_nxt.ram_inc = 1'b1;
        state_nxt.ram_addr = ram_ptr_in;
        state_nxt.ram_wdata = state_r.st_data[7:0];
        state_nxt.st = tmr_pair_pkg::ST_HIGH;
      end

      tmr_pair_pkg::ST_HIGH: begin
        // one above the low byte: the owner's step is not visible yet
        state_nxt.ram_we = 1'b1;
        state_nxt.ram_inc = 1'b1;
        state_nxt.ram_addr = state_r.ram_addr + 8'h01;
        state_nxt.ram_wdata = state_r.st_data[15:8];
        state_nxt.st = tmr_pair_pkg::ST_IDLE;
      end

      default: begin
        // stray code falls back to idle
        state_nxt.st = tmr_pair_pkg::ST_IDLE;
      end
    endcase

    for (int c = 0; c < 2; c++) begin
      ck = state_r.mode_a[c][tmr_pair_pkg::MA_CLK_MSB:0];
      fast = state_r.mode_b[c][tmr_pair_pkg::MB_FAST];

      // count clock source
      // fast mode swaps in the alternate taps
      case (ck)
        3'h0: src_clk = fast ? state_r.ps0_half : prescale_tap_in[1];
        3'h1: src_clk = fast ? prescale_tap_in[0] : prescale_tap_in[2];
        3'h2: src_clk = fast ? prescale_tap_in[6] : prescale_tap_in[3];
        3'h3: src_clk = fast ? prescale_tap_in[7] : prescale_tap_in[4];
        3'h4: src_clk = fast ? prescale_tap_in[8] : prescale_tap_in[5];
        tmr_pair_pkg::CK_FIRST_TMR: src_clk = first_timer_output_in;
        tmr_pair_pkg::CK_OTHER_TMR: begin
          // second takes the third; third may take the serial clock
          if (c == 0) begin
            src_clk = state_r.raw[1];
          end else begin
            src_clk = serial_clock_select_in ? serial_iface_clock_in : state_r.raw[0];
          end
        end
        default: src_clk = event_pins[c + int'(state_r.mode_a[c][tmr_pair_pkg::MA_SRC_LO])];
      endcase

      // active edge after optional inversion
      edge_in = src_clk ^ state_r.mode_b[c][tmr_pair_pkg::MB_CLK_INV];
      state_nxt.clk_prev[c] = edge_in;
      tick = edge_in && !state_r.clk_prev[c];

      // capture input and event
      cap_sig = ext_irqs[c + int'(state_r.mode_a[c][tmr_pair_pkg::MA_SRC_LO])];
      state_nxt.cap_prev[c] = cap_sig;
      if (state_r.mode_a[c][tmr_pair_pkg::MA_SRC_HI] && cap_sig && !state_r.cap_prev[c]) begin
        state_nxt.cap[c] = state_r.cnt[c];
        // a newer capture replaces one still waiting
        if (state_r.mode_b[c][tmr_pair_pkg::MB_TO_RAM]) begin
          state_nxt.pend[c] = 1'b1;
        end
      end

      // register writes
      // a write with the start bit restarts a running timer
      start = 1'b0;
      if (wr_in) begin
        if (addr_in == tmr_pair_pkg::OFF_MODE_A[c]) begin
          state_nxt.mode_a[c] = wdata_in;
          start = wdata_in[tmr_pair_pkg::MA_CLEAR_START];
        end else if (addr_in == tmr_pair_pkg::OFF_MODE_B[c]) begin
          // second timer has no combine field
          state_nxt.mode_b[c] = (c == 0) ? (wdata_in & tmr_pair_pkg::MB_SECOND_MASK) : wdata_in;
        end else if (addr_in == tmr_pair_pkg::OFF_DATA_LO[c]) begin
          state_nxt.dbuf[c][tmr_pair_pkg::SLOT_DUTY] = wdata_in;
        end else if (addr_in == tmr_pair_pkg::OFF_PERIOD[c]) begin
          state_nxt.dbuf[c][tmr_pair_pkg::SLOT_PERIOD] = wdata_in;
        end else if (addr_in == tmr_pair_pkg::OFF_DATA_HI[c]) begin
          state_nxt.dbuf[c][tmr_pair_pkg::SLOT_EXT] = wdata_in;
        end else if (addr_in == tmr_pair_pkg::OFF_CYCLE[c]) begin
          state_nxt.dbuf[c][tmr_pair_pkg::SLOT_CYCLE] = wdata_in;
        end
      end

      // counting
      ovf = 1'b0;
      lo = state_r.cnt[c][7:0];
      hi = state_r.cnt[c][15:8];
      end_lo = state_r.mode_a[c][tmr_pair_pkg::MA_PLUS_ONE] ?
               state_r.dact[c][tmr_pair_pkg::SLOT_PERIOD] :
               state_r.dact[c][tmr_pair_pkg::SLOT_PERIOD] - 8'h01;
      match = {state_r.dact[c][tmr_pair_pkg::SLOT_EXT], state_r.dact[c][tmr_pair_pkg::SLOT_DUTY]};
      if (start) begin
        // clear and restart, buffers go live
        state_nxt.cnt[c] = 16'h0000;
        state_nxt.dact[c] = state_nxt.dbuf[c];
        state_nxt.half[c] = 1'b0;
        state_nxt.raw[c] = 1'b0;
      end else if (!state_r.mode_a[c][tmr_pair_pkg::MA_CLEAR_START]) begin
        // stopped: count holds
        state_nxt.cnt[c] = state_r.cnt[c];
      end else if (state_r.mode_a[c][tmr_pair_pkg::MA_PAUSE_CONT] && tick) begin
        if (state_r.mode_b[c][tmr_pair_pkg::MB_PWM]) begin
          // low byte counts the period, high byte the cycles
          if (lo >= end_lo) begin
            lo = 8'h00;
            if (hi >= state_r.dact[c][tmr_pair_pkg::SLOT_CYCLE] - 8'h01) begin
              // last period of the cycle: reload, overflow
              hi = 8'h00;
              ovf = 1'b1;
              state_nxt.dact[c] = state_r.dbuf[c];
            end else begin
              hi = hi + 8'h01;
            end
          end else begin
            lo = lo + 8'h01;
          end
          state_nxt.cnt[c] = {hi, lo};
        end else if (state_r.cnt[c] == match) begin
          // interval end: reload, toggle the rectangular output
          state_nxt.cnt[c] = state_r.mode_a[c][tmr_pair_pkg::MA_PLUS_ONE] ? 16'h0000 : 16'h0001;
          state_nxt.raw[c] = !state_r.raw[c];
          state_nxt.dact[c] = state_r.dbuf[c];
          ovf = 1'b1;
        end else if (state_r.cnt[c] == tmr_pair_pkg::CNT_ALL_ONES) begin
          // no match before all ones: wrap
          state_nxt.cnt[c] = 16'h0000;
          ovf = 1'b1;
        end else begin
          // plain step
          state_nxt.cnt[c] = state_r.cnt[c] + 16'h0001;
        end
      end

      // pwm waveform: duty, one count longer in the first ext periods
      if (state_r.mode_b[c][tmr_pair_pkg::MB_PWM]) begin
        duty_x = {1'b0, state_r.dact[c][tmr_pair_pkg::SLOT_DUTY]} +
                 {8'h00, (state_r.cnt[c][15:8] < state_r.dact[c][tmr_pair_pkg::SLOT_EXT])};
        state_nxt.raw[c] = ({1'b0, state_r.cnt[c][7:0]} < duty_x);
      end

      // overflow thinning
      if (ovf) begin
        if (state_r.mode_b[c][tmr_pair_pkg::MB_IRQ_RATE]) begin
          state_nxt.irq[c] = 1'b1;
        end else begin
          state_nxt.irq[c] = state_r.half[c];
          // every second overflow: pass half, then flip it
          state_nxt.half[c] = !state_r.half[c];
        end
      end

      // polarity, one stage after raw
      state_nxt.outp[c] = state_r.raw[c] ^ state_r.mode_b[c][tmr_pair_pkg::MB_OUT_INV];
    end

    // combined output of both channels
    case (state_r.mode_b[1][tmr_pair_pkg::MB_COMB_MSB:tmr_pair_pkg::MB_COMB_LSB])
      tmr_pair_pkg::COMB_AND:  state_nxt.comb = state_r.outp[0] & state_r.outp[1];
      tmr_pair_pkg::COMB_OR:   state_nxt.comb = state_r.outp[0] | state_r.outp[1];
      tmr_pair_pkg::COMB_NAND: state_nxt.comb = !(state_r.outp[0] & state_r.outp[1]);
      // remaining code is nor
      default:                 state_nxt.comb = !(state_r.outp[0] | state_r.outp[1]);
    endcase

    // register reads, answer in the following cycle
    state_nxt.rdata = 8'h00;
    if (rd_in) begin
      // at most one offset matches per read
      for (int c = 0; c < 2; c++) begin
        if (addr_in == tmr_pair_pkg::OFF_MODE_A[c]) begin
          state_nxt.rdata = state_r.mode_a[c];
        end else if (addr_in == tmr_pair_pkg::OFF_MODE_B[c]) begin
          state_nxt.rdata = state_r.mode_b[c];
        end else if (addr_in == tmr_pair_pkg::OFF_DATA_LO[c]) begin
          if (state_r.mode_a[c][tmr_pair_pkg::MA_SRC_HI]) begin
            // capture mode shows the captured count
            state_nxt.rdata = state_r.cap[c][7:0];
            state_nxt.hi_latch[c] = state_r.cap[c][15:8];
          end else begin
            state_nxt.rdata = state_r.cnt[c][7:0];
            state_nxt.hi_latch[c] = state_r.cnt[c][15:8];
          end
        end else if (addr_in == tmr_pair_pkg::OFF_DATA_HI[c]) begin
          // high byte from the latch, not the live count
          state_nxt.rdata = state_r.hi_latch[c];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_r <= '0;
      // modes take their reset value, the rest clears
      state_r.mode_a <= {2{tmr_pair_pkg::MODE_RESET}};
      state_r.mode_b <= {2{tmr_pair_pkg::MODE_RESET}};
      state_r.st <= tmr_pair_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign rdata_out               = state_r.rdata;
  assign ram_addr_out            = state_r.ram_addr;
  assign ram_wdata_out           = state_r.ram_wdata;
  assign ram_we_out              = state_r.ram_we;
  assign ram_ptr_inc_out         = state_r.ram_inc;
  assign second_timer_output_out = state_r.outp[0];
  assign third_timer_output_out  = state_r.outp[1];
  assign combined_output_out     = state_r.comb;
  assign tmr_irq_out             = state_r.irq;

endmodule : tmr_pair

// File: rtl/tmr_pair_pkg.sv
// package for the dual 16-bit timer/pwm/capture block
// assumes an 8-bit register port and 8-bit data ram writes
package tmr_pair_pkg;

  // register offsets, index 0 = second timer, index 1 = third timer
  localparam logic [1:0][7:0] OFF_MODE_A = {8'h5d, 8'h57};
  localparam logic [1:0][7:0] OFF_MODE_B = {8'h5e, 8'h58};
  localparam logic [1:0][7:0] OFF_DATA_LO = {8'h5f, 8'h59};
  localparam logic [1:0][7:0] OFF_PERIOD = {8'h60, 8'h5a};
  localparam logic [1:0][7:0] OFF_DATA_HI = {8'h61, 8'h5b};
  localparam logic [1:0][7:0] OFF_CYCLE = {8'h62, 8'h5c};

  // mode a fields
  localparam int MA_CLEAR_START = 7;
  localparam int MA_PAUSE_CONT  = 6;
  localparam int MA_PLUS_ONE    = 5;
  localparam int MA_SRC_HI      = 4;
  localparam int MA_SRC_LO      = 3;
  localparam int MA_CLK_MSB     = 2;

  // mode b fields
  localparam int MB_COMB_MSB   = 7;
  localparam int MB_COMB_LSB   = 6;
  localparam int MB_PWM        = 5;
  localparam int MB_TO_RAM     = 4;
  localparam int MB_FAST       = 3;
  localparam int MB_IRQ_RATE   = 2;
  localparam int MB_OUT_INV    = 1;
  localparam int MB_CLK_INV    = 0;
  localparam logic [7:0] MB_SECOND_MASK = 8'h3f;

  // data buffer slots
  localparam int SLOT_DUTY   = 0;
  localparam int SLOT_PERIOD = 1;
  localparam int SLOT_EXT    = 2;
  localparam int SLOT_CYCLE  = 3;

  // clock select codes
  localparam logic [2:0] CK_FIRST_TMR = 3'h5;
  localparam logic [2:0] CK_OTHER_TMR = 3'h6;
  localparam logic [2:0] CK_EVENT     = 3'h7;

  // output combine codes
  localparam logic [1:0] COMB_AND  = 2'h0;
  localparam logic [1:0] COMB_OR   = 2'h1;
  localparam logic [1:0] COMB_NAND = 2'h2;

  // reset value and count wrap limit
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;

  // capture store engine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } store_e;

endpackage : tmr_pair_pkg

// File: verif/ram_owner_model.sv
// data ram owner: pointer register and byte store
// assumes one-cycle registered write and step pulses
`timescale 1ns/100ps
module ram_owner_model #(parameter logic [7:0] PTR_START = 8'h40) (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] ram_addr_in,
  input  wire logic [7:0] ram_wdata_in,
  input  wire logic       ram_we_in,
  input  wire logic       ram_ptr_inc_in,
  output logic      [7:0] ram_ptr_out
);
  logic [7:0] mem [256];
  // post-increment pointer, store each byte
  always @(posedge clock_in) begin
    if (!rst_b_in) ram_ptr_out <= PTR_START;
    else if (ram_ptr_inc_in) ram_ptr_out <= ram_ptr_out + 8'h01;
    if (rst_b_in && ram_we_in) mem[ram_addr_in] <= ram_wdata_in;
  end
endmodule : ram_owner_model

// File: verif/tb.sv
// self-checking bench for the dual timer block
// drives register port and pins; ram owner model takes the stores
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH at %0t: got %h want %h", $time, (g), (e)); end end
module tb;
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_r = 8'h00;
  logic [7:0]  wdata_r = 8'h00;
  logic        wr_r = 1'b0;
  logic        rd_r = 1'b0;
  logic        sel_r = 1'b0;
  logic [9:0]  stim_r = 10'h000;
  logic [7:0]  rdata, rd_val, ram_addr, ram_wdata, ram_ptr;
  logic        ram_we, ram_inc, out_b, out_c, out_comb, ob;
  logic [1:0]  irq;
  logic [15:0] cnt_val;
  int          bad_count = 0;
  int          n_compared = 0;
  int          irq_n = 0;
  // timer, mode b, mode a, stimulus bit, ticks
  int ctb [5][5] = '{'{0, 0, 8'hc5, 3, 4}, '{0, 0, 8'hc0, 7, 2}, '{0, 8'h08, 8'hc1, 8, 3},
                     '{1, 0, 8'hc6, 4, 3}, '{1, 0, 8'hcf, 2, 2}};
  // mode b, mode a, expected irq pulses over 12 ticks
  int itb [3][3] = '{'{8'h04, 8'he7, 4}, '{8'h00, 8'he7, 2}, '{8'h04, 8'hc7, 5}};
  always #4 clock_in = ~clock_in;
  tmr_pair DUT (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_r), .wdata_in(wdata_r), .wr_in(wr_r),
    .rd_in(rd_r), .rdata_out(rdata), .prescale_tap_in({7'h00, stim_r[7], stim_r[8]}),
    .first_timer_output_in(stim_r[3]), .serial_iface_clock_in(stim_r[4]), .serial_clock_select_in(sel_r),
    .event_pin_a_in(stim_r[0]), .event_pin_b_in(stim_r[1]), .event_pin_c_in(stim_r[2]),
    .ext_irq_a_in(stim_r[5]), .ext_irq_b_in(stim_r[6]), .ext_irq_c_in(stim_r[9]), .ram_ptr_in(ram_ptr),
    .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata), .ram_we_out(ram_we), .ram_ptr_inc_out(ram_inc),
    .second_timer_output_out(out_b), .third_timer_output_out(out_c), .combined_output_out(out_comb),
    .tmr_irq_out(irq));
  ram_owner_model u_ram (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata),
    .ram_we_in(ram_we), .ram_ptr_inc_in(ram_inc), .ram_ptr_out(ram_ptr));
  // count second timer irq pulses
  always @(posedge clock_in) begin
    if (irq[0] === 1'b1) irq_n <= irq_n + 1;
  end
  function automatic logic [7:0] ad(input int i, input int r);
    case (r)
      0: return tmr_pair_pkg::OFF_MODE_A[i];
      1: return tmr_pair_pkg::OFF_MODE_B[i];
      2: return tmr_pair_pkg::OFF_DATA_LO[i];
      default: return tmr_pair_pkg::OFF_DATA_HI[i];
    endcase
  endfunction : ad
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_r <= 1'b1;
    addr_r <= a;
    wdata_r <= d;
    @(posedge clock_in);
    wr_r <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    rd_r <= 1'b1;
    addr_r <= a;
    @(posedge clock_in);
    rd_r <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd
  // low byte first, high byte then
  task automatic cnt(input int i);
    rd(ad(i, 2));
    cnt_val[7:0] = rd_val;
    rd(ad(i, 3));
    cnt_val[15:8] = rd_val;
  endtask : cnt
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge clock_in);
      stim_r[s] <= 1'b1;
      repeat (3) @(posedge clock_in);
      stim_r[s] <= 1'b0;
      repeat (3) @(posedge clock_in);
    end
  endtask : pulse
  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // bounded wait for the ram pointer
  task automatic wait_ptr(input logic [7:0] p);
    for (int k = 0; k < 40 && ram_ptr !== p; k++) @(posedge clock_in);
    `CHK(ram_ptr, p)
    if (ram_ptr !== p) report_and_stop();
  endtask : wait_ptr
  initial begin
    logic [7:0] ra [5];
    int base;
    ra = '{8'h57, 8'h58, 8'h5d, 8'h5e, 8'h70};
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // mode registers clear, unmapped reads zero
    for (int k = 0; k < 5; k++) begin
      rd(ra[k]);
      `CHK(rd_val, 8'h00)
    end
    wr(8'h58, 8'hff);
    rd(8'h58);
    `CHK(rd_val, 8'h3f)
    // pause, clear/start, counter read, clock invert per timer
    for (int i = 0; i < 2; i++) begin
      wr(ad(i, 2), 8'hff);
      wr(ad(i, 3), 8'hff);
      wr(ad(i, 1), 8'h00);
      wr(ad(i, 0), 8'h87);
      pulse(i, 3);
      cnt(i);
      `CHK(cnt_val, 16'h0000)
      wr(ad(i, 0), 8'hc7);
      pulse(i, 5);
      cnt(i);
      `CHK(cnt_val, 16'h0005)
      wr(ad(i, 1), 8'h01);
      wr(ad(i, 0), 8'hc7);
      stim_r[i] <= 1'b1;
      repeat (4) @(posedge clock_in);
      cnt(i);
      `CHK(cnt_val, 16'h0000)
      @(posedge clock_in) stim_r[i] <= 1'b0;
      repeat (4) @(posedge clock_in);
      cnt(i);
      `CHK(cnt_val, 16'h0001)
    end
    // clock source codes
    @(posedge clock_in) sel_r <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      wr(ad(ctb[k][0], 1), 8'(ctb[k][1]));
      wr(ad(ctb[k][0], 0), 8'(ctb[k][2]));
      pulse(ctb[k][3], ctb[k][4]);
      cnt(ctb[k][0]);
      `CHK(cnt_val, 16'(ctb[k][4]))
    end
    // interval match and irq rate
    wr(ad(0, 2), 8'h02);
    wr(ad(0, 3), 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(ad(0, 1), 8'(itb[k][0]));
      wr(ad(0, 0), 8'(itb[k][1]));
      base = irq_n;
      pulse(0, 12);
      `CHK(irq_n - base, itb[k][2])
    end
    // polarity and combine codes
    for (int i = 0; i < 8; i++) begin
      wr(ad(0, 1), {6'h00, i[2], 1'b0});
      wr(ad(1, 1), {i[1:0], 6'h00});
      repeat (4) @(posedge clock_in);
      #2;
      `CHK(out_comb, i[1] ^ (i[0] ? (out_b | out_c) : (out_b & out_c)))
      if (i == 3) ob = out_b;
      if (i == 4) `CHK(out_b, ~ob)
    end
    // capture stored to ram, two captures
    wr(ad(0, 2), 8'hff);
    wr(ad(0, 3), 8'hff);
    wr(ad(0, 1), 8'h10);
    wr(ad(0, 0), 8'hd7);
    pulse(0, 3);
    pulse(5, 1);
    wait_ptr(8'h42);
    `CHK(u_ram.mem[8'h40], 8'h03)
    `CHK(u_ram.mem[8'h41], 8'h00)
    pulse(0, 2);
    pulse(5, 1);
    wait_ptr(8'h44);
    `CHK(u_ram.mem[8'h42], 8'h05)
    rd(8'h59);
    `CHK(rd_val, 8'h05)
    wr(ad(0, 1), 8'h00);
    pulse(5, 1);
    `CHK(ram_ptr, 8'h44)
    // third timer capture on its second interrupt pin
    wr(8'h5d, 8'hdf);
    pulse(2, 3);
    pulse(9, 1);
    rd(8'h5f);
    `CHK(rd_val, 8'h03)
    // pwm on the second timer: duty 1, period 3, extension 0, cycle 2
    wr(8'h59, 8'h01);
    wr(8'h5a, 8'h03);
    wr(8'h5b, 8'h00);
    wr(8'h5c, 8'h02);
    wr(8'h58, 8'h24);
    wr(8'h57, 8'hc7);
    base = irq_n;
    pulse(0, 4);
    cnt(0);
    `CHK(cnt_val, 16'h0101)
    `CHK(out_b, 1'b0)
    pulse(0, 2);
    cnt(0);
    `CHK(cnt_val, 16'h0000)
    `CHK(out_b, 1'b1)
    `CHK(irq_n - base, 1)
    report_and_stop();
  end
endmodule : tb
bind tmr_pair tmr_pair_asserts u_chk (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .ram_addr_out(ram_addr_out), .ram_we_out(ram_we_out),
  .ram_ptr_inc_out(ram_ptr_inc_out), .second_timer_output_out(second_timer_output_out),
  .third_timer_output_out(third_timer_output_out), .combined_output_out(combined_output_out),
  .tmr_irq_out(tmr_irq_out));

// File: verif/tmr_pair_asserts.sv
// checker for the dual timer block, port level only
// bound to tmr_pair from the bench top file
`timescale 1ns/100ps
module tmr_pair_asserts (
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] ram_addr_out,
  input wire logic       ram_we_out,
  input wire logic       ram_ptr_inc_out,
  input wire logic       second_timer_output_out,
  input wire logic       third_timer_output_out,
  input wire logic       combined_output_out,
  input wire logic [1:0] tmr_irq_out
);
  logic [1:0] comb_r;
  logic       comb_x;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // mirror of the combine field
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) comb_r <= 2'h0;
    else if (wr_in && addr_in == 8'h5e) comb_r <= wdata_in[7:6];
  end
  // expected combined level
  assign comb_x = comb_r[1] ^ (comb_r[0] ? (second_timer_output_out | third_timer_output_out)
                                         : (second_timer_output_out & third_timer_output_out));
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    $past(rd_in) && ($past(addr_in) < 8'h57 || $past(addr_in) > 8'h62) |-> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_we_inc; ram_we_out == ram_ptr_inc_out; endproperty
  a_we_inc: assert property (p_we_inc) else $error("pointer step apart from write");
  property p_we_pair; $rose(ram_we_out) |-> ##1 ram_we_out ##1 !ram_we_out; endproperty
  a_we_pair: assert property (p_we_pair) else $error("store not two bytes");
  property p_addr_step; $rose(ram_we_out) |=> ram_addr_out == $past(ram_addr_out) + 8'h01; endproperty
  a_addr_step: assert property (p_addr_step) else $error("high byte address wrong");
  property p_irq0; tmr_irq_out[0] |=> !tmr_irq_out[0]; endproperty
  a_irq0: assert property (p_irq0) else $error("second irq not a pulse");
  property p_irq1; tmr_irq_out[1] |=> !tmr_irq_out[1]; endproperty
  a_irq1: assert property (p_irq1) else $error("third irq not a pulse");
  property p_comb;
    ($stable(second_timer_output_out) && $stable(third_timer_output_out) && $stable(comb_r)) [*3]
      |-> combined_output_out == comb_x;
  endproperty
  a_comb: assert property (p_comb) else $error("combined output wrong");
  c_store: cover property ($rose(ram_we_out));
  c_irq: cover property (tmr_irq_out[0]);
  c_comb: cover property ($rose(combined_output_out));
endmodule : tmr_pair_asserts
